/* dv/spmvm_periph.sv */
`timescale 1ns/10ps
`default_nettype none
module spmvm_periph
   import spmvm_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic [19:0]   flagSet,
   input  wire logic          extRun,
   output var  spmvm_serial_t serialFlags,
   output var  logic [3:0]    srcFlags,
   output var  spmvm_timer_t  timerOne,
   output var  spmvm_timer_t  timerTwo,
   output var  logic          extWakeClk
);
   // source flags change just after the edge; wakeup clock still unless running
   always @(posedge mclk) begin
      {serialFlags, srcFlags, timerOne, timerTwo} <= flagSet;
      extWakeClk <= extRun & ~extWakeClk;
   end
endmodule : spmvm_periph
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import spmvm_pkg::*;
;
   localparam int TICK = 4;
   logic          mclk = 1'b0;
   logic          rstB = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0000_0000;
   logic          supplyBelow = 1'b0;
   logic          testMode = 1'b0;
   logic          stopMode = 1'b0;
   logic          extRun = 1'b0;
   logic [19:0]   flagSet = 20'h0_0000;
   logic [31:0]   prdata;
   logic          pready, pslverr, lvReset, lvIrq, detectorOn, refBufEnable;
   logic          wakeTimeout, extWakeClk;
   logic [3:0]    srcFlags;
   spmvm_serial_t serialFlags;
   spmvm_timer_t  timerOne, timerTwo;
   int            errTotal = 0;
   int            testsRun = 0;
   logic [32:0]   expQ[$];
   logic [31:0]   seed = 32'h0000_005A;
   int            tbl[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};

   always #2.5 mclk = ~mclk;

   spmvm_top #(.TICK_CYCLES(TICK)) u_spmvm_top (
      .mclk(mclk), .rst_b(rstB), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supplyBelow(supplyBelow), .testMode(testMode), .stopMode(stopMode),
      .extWakeClk(extWakeClk), .serialFlags(serialFlags), .convFlag(srcFlags[3]),
      .keypadFlag(srcFlags[2]), .displayFlag(srcFlags[1]), .wakeFlag(srcFlags[0]),
      .timerOne(timerOne), .timerTwo(timerTwo), .lvReset(lvReset), .lvIrq(lvIrq),
      .detectorOn(detectorOn), .refBufEnable(refBufEnable), .wakeTimeout(wakeTimeout));

   spmvm_periph u_spmvm_periph (
      .mclk(mclk), .flagSet(flagSet), .extRun(extRun), .serialFlags(serialFlags),
      .srcFlags(srcFlags), .timerOne(timerOne), .timerTwo(timerTwo),
      .extWakeClk(extWakeClk));

   task automatic stopTest();
      if (errTotal == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stopTest

   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      testsRun++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         errTotal++;
      end
   endtask : cmp

   task automatic chk(input logic g, input logic e);
      cmp({32'h0000_0000, g}, {32'h0000_0000, e});
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   // one transfer; the expected answer is noted before the request goes out
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic err);
      int i;
      expQ.push_back({24'h00_0000, (wr ? 8'h00 : e), err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         errTotal++;
         stopTest();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, e, 1'b0);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 8'h00, 1'b0);
   endtask : wr

   task automatic waitPulse(input int lim, output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wakeTimeout !== 1'b1 && n < lim);
   endtask : waitPulse

   task automatic doReset();
      rstB <= 1'b0;
      cyc(3);
      rstB <= 1'b1;
      cyc(7);
   endtask : doReset

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // answers are compared as they appear, oldest note first
   always @(posedge mclk) begin
      if (psel && penable && pready) begin
         cmp({prdata, pslverr}, expQ.pop_front());
      end
   end

   initial begin
      logic [19:0] r;
      logic [7:0]  expOne;
      int          n;
      doReset();
      rd(OFS_POWER_MON, 8'h94);
      rd(OFS_PENDING_ONE, 8'h00);
      apb(1'b0, 12'h010, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 12'h010, 8'hFF, 8'h00, 1'b1);
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         r = seed[19:0];
         flagSet <= r;
         cyc(3);
         expOne = {1'b0, |r[19:18], |r[17:14], |r[13:10], r[9:6]};
         rd(OFS_PENDING_ONE, expOne);
         rd(OFS_PENDING_TWO, {1'b0, r[2:0], 1'b0, r[5:3]});
      end
      wr(OFS_PENDING_TWO, 8'hFF);
      rd(OFS_PENDING_TWO, {1'b0, r[2:0], 1'b0, r[5:3]});
      flagSet <= 20'h0_0000;
      wr(OFS_POWER_MON, 8'h25);
      rd(OFS_POWER_MON, 8'hA5);
      chk(refBufEnable, 1'b1);
      wr(OFS_POWER_MON, 8'h3C);
      rd(OFS_POWER_MON, 8'hA4);
      chk(refBufEnable, 1'b0);
      stopMode <= 1'b1;
      cyc(3);
      chk(detectorOn, 1'b0);
      stopMode <= 1'b0;
      cyc(3);
      chk(detectorOn, 1'b1);
      supplyBelow <= 1'b1;
      cyc(4);
      chk(lvIrq, 1'b1);
      chk(lvReset, 1'b0);
      rd(OFS_POWER_MON, 8'h24);
      rd(OFS_PENDING_ONE, 8'h80);
      wr(OFS_POWER_MON, 8'h64);
      cyc(2);
      chk(lvIrq, 1'b0);
      rd(OFS_POWER_MON, 8'h24);
      supplyBelow <= 1'b0;
      cyc(2);
      wr(OFS_POWER_MON, 8'h64);
      rd(OFS_POWER_MON, 8'hA4);
      supplyBelow <= 1'b1;
      doReset();
      chk(lvReset, 1'b1);
      wr(OFS_POWER_MON, 8'h3C);
      cyc(2);
      chk(lvIrq, 1'b0);
      stopMode <= 1'b1;
      cyc(3);
      chk(detectorOn, 1'b1);
      stopMode <= 1'b0;
      testMode <= 1'b1;
      cyc(3);
      chk(lvReset, 1'b0);
      chk(lvIrq, 1'b1);
      testMode <= 1'b0;
      supplyBelow <= 1'b0;
      for (int c = 1; c < 8; c++) begin
         wr(OFS_WAKEUP_CTRL, 8'(c));
         waitPulse(9000, n);
         waitPulse(9000, n);
         cmp(33'(n), 33'(tbl[c] * TICK));
      end
      extRun <= 1'b1;
      wr(OFS_WAKEUP_CTRL, 8'h21);
      waitPulse(9000, n);
      waitPulse(9000, n);
      cmp(33'(n), 33'(256 * 2));
      wr(OFS_WAKEUP_CTRL, 8'h00);
      waitPulse(2000, n);
      cmp(33'(n), 33'(2000));
      extRun <= 1'b0;
      stopTest();
   end
endmodule : tb_top
`default_nettype wire

/* logic/spmvm_top.sv */
// Summary of operation
// - internal clock: period codes, 000 disables
// - external clock: codes count external periods
// - flag bit reads 0 when low voltage
// - acknowledge clears request, flag if recovered
// - interrupt enable acts only with detector
// - reset enable forces reset, beats interrupt
// - test mode treats reset enable as off
// - stop enable keeps detector on in stop
// - detector enable gates all detector controls; code leaves bit 0 buffer enable ungated
// - bit 0 enables reference buffer output
// - some control bits are write once
// - flag sets when supply below warning
// - pending one bit 7 low voltage
// - pending one bit 6 serial transmit
// - pending one bit 5 serial receive
// - pending one bit 4 serial error
// - bits 3..0 converter keypad display wakeup
// - pending bits read only, reset clears
// - pending two bits 6..4 second timer
// - pending two bits 2..0 first timer
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module spmvm_top
   import spmvm_pkg::*;
#(
   parameter int TICK_CYCLES = WAKE_TICK_CYCLES
) (
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          supplyBelow,
   input  wire logic          testMode,
   input  wire logic          stopMode,
   input  wire logic          extWakeClk,
   input  wire spmvm_serial_t serialFlags,
   input  wire logic          convFlag,
   input  wire logic          keypadFlag,
   input  wire logic          displayFlag,
   input  wire logic          wakeFlag,
   input  wire spmvm_timer_t  timerOne,
   input  wire spmvm_timer_t  timerTwo,
   output logic               lvReset,
   output logic               lvIrq,
   output logic               detectorOn,
   output logic               refBufEnable,
   output logic               wakeTimeout
);

   if (TICK_CYCLES < 2 || TICK_CYCLES > 262143) begin : g_chk
      $error("TICK_CYCLES out of range");
   end

   function automatic logic [15:0] wakeLimit(input logic [2:0] code, input logic ext);
      logic [15:0] lim;
      lim = 16'h0000;
      case (code)
         3'h1: lim = ext ? WK_EXT_1 : WK_INT_1;
         3'h2: lim = ext ? WK_EXT_2 : WK_INT_2;
         3'h3: lim = ext ? WK_EXT_3 : WK_INT_3;
         3'h4: lim = ext ? WK_EXT_4 : WK_INT_4;
         3'h5: lim = ext ? WK_EXT_5 : WK_INT_5;
         3'h6: lim = ext ? WK_EXT_6 : WK_INT_6;
         3'h7: lim = ext ? WK_EXT_7 : WK_INT_7;
         default: lim = 16'h0000;
      endcase
      return lim;
   endfunction : wakeLimit

   logic rstMeta;
   logic rstN;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta <= 1'b0;
         rstN    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN    <= rstMeta;
      end
   end

   // bus decode
   wire        access  = psel & penable;
   wire        xferEnd = access & pready;
   wire        selPm   = (paddr == OFS_POWER_MON);
   wire        selP1   = (paddr == OFS_PENDING_ONE);
   wire        selP2   = (paddr == OFS_PENDING_TWO);
   wire        selWk   = (paddr == OFS_WAKEUP_CTRL);
   wire        mapped  = selPm | selP1 | selP2 | selWk;
   wire        wrPm    = xferEnd & pwrite & selPm;
   wire        wrWk    = xferEnd & pwrite & selWk;

   // control registers
   logic       irqEn;
   logic       rstEn;
   logic       stopEn;
   logic       detEn;
   logic       bufEn;
   logic       onceDone;
   logic [2:0] periodSel;
   logic       extSel;
   logic       lvFlag;
   logic [7:0] pendOne;
   logic [7:0] pendTwo;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         irqEn    <= PM_IRQEN_RST;
         rstEn    <= PM_RSTEN_RST;
         stopEn   <= PM_STOPEN_RST;
         detEn    <= PM_DETEN_RST;
         bufEn    <= PM_BUFEN_RST;
         onceDone <= 1'b0;
      end else if (wrPm) begin
         irqEn <= pwdata[PM_IRQEN_BIT];
         bufEn <= pwdata[PM_BUFEN_BIT];
         if (!onceDone) begin
            rstEn    <= pwdata[PM_RSTEN_BIT];
            stopEn   <= pwdata[PM_STOPEN_BIT];
            detEn    <= pwdata[PM_DETEN_BIT];
            onceDone <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         periodSel <= WK_PERIOD_RST;
         extSel    <= WK_CLKSEL_RST;
      end else if (wrWk) begin
         periodSel <= pwdata[WK_PERIOD_LSB +: 3];
         extSel    <= pwdata[WK_CLKSEL_BIT];
      end
   end

   // low voltage detector
   wire detActive  = detEn & (~stopMode | stopEn);
   wire lvSet      = detActive & supplyBelow;
   wire ackWrite   = wrPm & pwdata[PM_ACK_BIT];
   wire rstArmed   = detEn & rstEn & ~testMode;
   wire next_flag  = lvSet | (lvFlag & ~(ackWrite & ~supplyBelow));
   wire next_reset = lvSet & rstArmed;
   wire next_irq   = next_flag & detEn & irqEn & ~rstArmed;

   // acknowledge holds the request off until a fresh detection; a fresh one beats it
   logic irqAck;
   logic lvSeen;
   wire  newLow  = lvSet & ~lvSeen;
   wire  irqHold = (ackWrite | irqAck) & ~newLow;
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         lvFlag       <= 1'b0;
         lvSeen       <= 1'b0;
         irqAck       <= 1'b0;
         lvReset      <= 1'b0;
         lvIrq        <= 1'b0;
         detectorOn   <= 1'b0;
         refBufEnable <= 1'b0;
      end else begin
         lvFlag       <= next_flag;
         lvSeen       <= lvSet;
         irqAck       <= irqHold;
         lvReset      <= next_reset;
         lvIrq        <= next_irq & ~irqHold;
         detectorOn   <= detActive;
         refBufEnable <= bufEn;
      end
   end

   // pending summaries
   wire serTx  = serialFlags.txEmpty | serialFlags.txDone;
   wire serRx  = serialFlags.rxIdle | serialFlags.rxFull
                 | serialFlags.breakDetect | serialFlags.rxEdge;
   wire serErr = serialFlags.overrun | serialFlags.noiseError
                 | serialFlags.framingError | serialFlags.parityError;
   wire [7:0] next_pendOne = {lvIrq, serTx, serRx, serErr,
                              convFlag, keypadFlag, displayFlag, wakeFlag};
   wire [7:0] next_pendTwo = {1'b0, timerTwo.channelOne, timerTwo.channelZero,
                              timerTwo.overflow, 1'b0, timerOne.channelOne,
                              timerOne.channelZero, timerOne.overflow};

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         pendOne <= PEND_RST;
         pendTwo <= PEND_RST;
      end else begin
         pendOne <= next_pendOne;
         pendTwo <= next_pendTwo;
      end
   end

   // wakeup timer
   logic [17:0] tickCnt;
   logic [15:0] wakeCnt;
   logic        extPrev;
   logic [2:0]  periodSeen;
   logic        extSeen;
   wire         msTick     = (tickCnt == 18'(TICK_CYCLES - 1));
   wire         extRise    = extWakeClk & ~extPrev;
   wire         wakeStep   = extSel ? extRise : msTick;
   wire [15:0]  limit      = wakeLimit(periodSel, extSel);
   wire         cfgChange  = (periodSel != periodSeen) | (extSel != extSeen);
   wire         wakeOn     = (periodSel != 3'h0);
   wire         wakeHit    = wakeOn & wakeStep & (wakeCnt == limit - 16'h0001);

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         tickCnt     <= 18'h0_0000;
         wakeCnt     <= 16'h0000;
         extPrev     <= 1'b0;
         periodSeen  <= WK_PERIOD_RST;
         extSeen     <= WK_CLKSEL_RST;
         wakeTimeout <= 1'b0;
      end else begin
         extPrev    <= extWakeClk;
         periodSeen <= periodSel;
         extSeen    <= extSel;
         tickCnt    <= (msTick | cfgChange) ? 18'h0_0000 : tickCnt + 18'h0_0001;
         if (!wakeOn || cfgChange || wakeHit) begin
            wakeCnt <= 16'h0000;
         end else if (wakeStep) begin
            wakeCnt <= wakeCnt + 16'h0001;
         end
         wakeTimeout <= wakeHit & ~cfgChange;
      end
   end

   // read mux
   wire       flagRead = detEn ? ~lvFlag : 1'b1;
   wire [7:0] pmRead   = {flagRead, 1'b0, irqEn, rstEn, stopEn, detEn,
                          1'b0, bufEn};
   wire [7:0] wkRead   = {2'b00, extSel, 2'b00, periodSel};
   wire [7:0] rdByte   = selPm ? pmRead :
                         selP1 ? pendOne :
                         selP2 ? pendTwo :
                         selWk ? wkRead : 8'h00;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access & ~pready;
         prdata  <= (access & ~pready & ~pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
         pslverr <= access & ~pready & ~mapped;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstN);

   ack_clears_flag_a: assert property (ackWrite & ~lvSet & ~supplyBelow |=> !lvFlag)
      else $error("acknowledge did not clear flag");
   flag_sets_a: assert property (lvSet |=> lvFlag && $past(detActive))
      else $error("flag not set while supply low");
   reset_over_irq_a: assert property (lvReset |-> !lvIrq)
      else $error("interrupt raised alongside reset");
   test_no_reset_a: assert property (testMode |=> !lvReset)
      else $error("reset raised in test mode");
   once_lock_a: assert property (onceDone && wrPm |=> $stable(detEn) && $stable(rstEn))
      else $error("write once bit changed");
   irq_gate_a: assert property (lvIrq |-> $past(detEn) && $past(irqEn))
      else $error("interrupt without enables");
   pend_mirror_a: assert property ($past(rstN) |->
      pendTwo == {1'b0, $past(timerTwo), 1'b0, $past(timerOne)})
      else $error("pending two mismatch");
   wake_off_a: assert property (!wakeOn [*2] |=> !wakeTimeout)
      else $error("timeout while timer disabled");
   flag_read_a: assert property (detEn && lvFlag |-> pmRead[PM_FLAG_BIT] == 1'b0)
      else $error("flag read polarity wrong");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   ack_drops_irq_a: assert property (ackWrite & ~newLow |=> !lvIrq)
      else $error("acknowledge did not drop interrupt");
   stop_off_a: assert property (stopMode & ~stopEn |=> !detectorOn)
      else $error("detector on in stop");
   det_off_a: assert property (!detEn |=> !detectorOn && !lvIrq && !lvReset)
      else $error("detector output while disabled");
   pend_low_a: assert property ($past(rstN) |->
      pendOne[3:0] == $past({convFlag, keypadFlag, displayFlag, wakeFlag}))
      else $error("pending one low bits mismatch");
   pend_tx_a: assert property ($past(rstN) |->
      pendOne[P1_TX_BIT] == $past(serialFlags.txEmpty | serialFlags.txDone))
      else $error("pending transmit mismatch");
   unmapped_err_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer without zero data");
   wake_gap_a: assert property (wakeTimeout |=> !wakeTimeout)
      else $error("timeout pulse too long");

endmodule : spmvm_top
`default_nettype wire

/* pkg/spmvm_pkg.sv */
package spmvm_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_POWER_MON    = 12'h000;
   localparam logic [11:0] OFS_PENDING_ONE  = 12'h004;
   localparam logic [11:0] OFS_PENDING_TWO  = 12'h008;
   localparam logic [11:0] OFS_WAKEUP_CTRL  = 12'h00C;

   // power monitor fields
   localparam int          PM_FLAG_BIT      = 7;
   localparam int          PM_ACK_BIT       = 6;
   localparam int          PM_IRQEN_BIT     = 5;
   localparam int          PM_RSTEN_BIT     = 4;
   localparam int          PM_STOPEN_BIT    = 3;
   localparam int          PM_DETEN_BIT     = 2;
   localparam int          PM_BUFEN_BIT     = 0;
   localparam logic        PM_IRQEN_RST     = 1'b0;
   localparam logic        PM_RSTEN_RST     = 1'b1;
   localparam logic        PM_STOPEN_RST    = 1'b0;
   localparam logic        PM_DETEN_RST     = 1'b1;
   localparam logic        PM_BUFEN_RST     = 1'b0;

   // wakeup control fields
   localparam int          WK_CLKSEL_BIT    = 5;
   localparam int          WK_PERIOD_LSB    = 0;
   localparam logic [2:0]  WK_PERIOD_RST    = 3'h0;
   localparam logic        WK_CLKSEL_RST    = 1'b0;

   // pending one fields
   localparam int          P1_LVD_BIT       = 7;
   localparam int          P1_TX_BIT        = 6;
   localparam int          P1_RX_BIT        = 5;
   localparam int          P1_ERR_BIT       = 4;
   localparam int          P1_CONV_BIT      = 3;
   localparam int          P1_KEY_BIT       = 2;
   localparam int          P1_DISP_BIT      = 1;
   localparam int          P1_WAKE_BIT      = 0;
   // pending two fields
   localparam int          P2_T2CH1_BIT     = 6;
   localparam int          P2_T2CH0_BIT     = 5;
   localparam int          P2_T2OVF_BIT     = 4;
   localparam int          P2_T1CH1_BIT     = 2;
   localparam int          P2_T1CH0_BIT     = 1;
   localparam int          P2_T1OVF_BIT     = 0;
   localparam logic [7:0]  PEND_RST         = 8'h00;

   // timing
   localparam int          CLK_PERIOD_PS    = 5000;
   localparam int          WAKE_TICK_NS     = 1000000;
   localparam int          WAKE_TICK_CYCLES = (WAKE_TICK_NS * 1000) / CLK_PERIOD_PS;

   // wakeup timeouts, internal in ms ticks and external in periods
   localparam logic [15:0] WK_INT_1 = 16'h0008;
   localparam logic [15:0] WK_INT_2 = 16'h0020;
   localparam logic [15:0] WK_INT_3 = 16'h0040;
   localparam logic [15:0] WK_INT_4 = 16'h0080;
   localparam logic [15:0] WK_INT_5 = 16'h0100;
   localparam logic [15:0] WK_INT_6 = 16'h0200;
   localparam logic [15:0] WK_INT_7 = 16'h0400;
   localparam logic [15:0] WK_EXT_1 = 16'h0100;
   localparam logic [15:0] WK_EXT_2 = 16'h0400;
   localparam logic [15:0] WK_EXT_3 = 16'h0800;
   localparam logic [15:0] WK_EXT_4 = 16'h1000;
   localparam logic [15:0] WK_EXT_5 = 16'h2000;
   localparam logic [15:0] WK_EXT_6 = 16'h3F9C;
   localparam logic [15:0] WK_EXT_7 = 16'h8000;

   typedef struct packed {
      logic txEmpty;
      logic txDone;
      logic rxIdle;
      logic rxFull;
      logic breakDetect;
      logic rxEdge;
      logic overrun;
      logic noiseError;
      logic framingError;
      logic parityError;
   } spmvm_serial_t;

   typedef struct packed {
      logic channelOne;
      logic channelZero;
      logic overflow;
   } spmvm_timer_t;
endpackage : spmvm_pkg
